// ==== scp_pkg.sv ====
// Constants, types and state layout for the serial configuration port
package scp_pkg;

    // Register map
    localparam int         NUM_REGS       = 563;
    localparam int         NUM_LVPECL     = 6;
    localparam logic [9:0] ADDR_PORT_CFG  = 10'h000;
    localparam logic [9:0] ADDR_READ_SEL  = 10'h004;
    localparam logic [9:0] ADDR_PLL_MODE  = 10'h010;
    localparam logic [9:0] ADDR_LVPECL0   = 10'h0F0;
    localparam logic [9:0] ADDR_DIST_CTRL = 10'h230;
    localparam logic [9:0] ADDR_UPDATE    = 10'h232;
    localparam logic [9:0] ADDR_LAST      = 10'h232;

    // Field positions
    localparam int BIT_SDO_ACT   = 0;
    localparam int BIT_LSB_FIRST = 1;
    localparam int BIT_SRST_LO   = 2;
    localparam int BIT_SRST_HI   = 5;
    localparam int BIT_READ_ACT  = 0;
    localparam int BIT_DIST_PD   = 1;
    localparam int BIT_UPDATE    = 0;

    // Reset values
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [7:0] OTHER_RST    = 8'h00;

    // Length field codes and power modes
    localparam logic [1:0] LEN_STREAM   = 2'h3;
    localparam logic [1:0] PLL_ASYNC_PD = 2'h1;
    localparam logic [1:0] PLL_SYNC_PD  = 2'h3;
    localparam logic [1:0] PECL_ON      = 2'h0;
    localparam logic [1:0] PECL_SAFE    = 2'h2;
    localparam logic [1:0] PECL_TOTAL   = 2'h3;

    typedef enum logic [2:0] {
        ST_INSTR = 3'b001,
        ST_DATA  = 3'b010,
        ST_DONE  = 3'b100
    } port_state_e;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
    } wr_entry_s;

    typedef struct packed {
        logic        pll_off;
        logic        core_off;
        logic        dist_off;
        logic [11:0] lvpecl_mode;
    } power_s;

    typedef struct packed {
        port_state_e     st;
        logic            sclk_q;
        logic [2:0]      bit_cnt;
        logic            ib;
        logic [15:0]     sh;
        logic            rd;
        logic            stream;
        logic [1:0]      left;
        logic [9:0]      addr;
        logic [7:0]      out_sh;
        logic            dout;
        logic [1:0]      fcnt;
        wr_entry_s [1:0] fifo;
        logic            upd;
        logic            sync_pend;
        logic            pll_pd;
        logic            hold;
        logic            align;
        power_s          pwr;
    } state_s;

    localparam state_s STATE_RST = '{st: ST_INSTR, hold: 1'b1, default: '0};

endpackage : scp_pkg

// ==== serial_config_port.sv ====
// Serial configuration port with register buffer, reset and power-down control
`timescale 1ns/100ps

// How it works
// - Power-up loads defaults, then pulses output alignment
// - Reset pin low forces all registers default
// - Soft reset while both mirrored bits are one
// - Soft reset bits act at once, no update
// - Sleep pin low powers down, settings kept
// - Sleep stops PLL and dividers, port stays live
// - Waking needs no calibration nor automatic alignment
// - Two-bit field picks PLL power mode
// - Asynchronous mode powers PLL down at update
// - Synchronous mode waits for charge-pump event
// - Distribution bit removes distribution section bias
// - LVPECL field: normal, safe-off or total off
// - Sample on rising edge, launch for falling
// - Direction bit picks shared or separate readback
// - Chip select high floats both data pins
// - Select may pause only on byte boundaries
// - Select rising mid-byte drops partial data
// - Streaming steps address until the byte at the last address (0x232) or select rising mid-byte
// - Long instruction only, bidirectional after reset
// - Any register, any length, either bit order
// - Instruction: read flag, length, 10-bit address in the low bits
// - Length codes one to three bytes, streaming
// - Address falls when MSB first, rises otherwise
// - Update bit copies buffer into active registers
module serial_config_port (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           srst_i,
    // Device pins
    input  wire logic           chip_reset_n_i,
    input  wire logic           sleep_pin_n_i,
    input  wire logic           cp_event_i,
    // Serial port pins
    input  wire logic           cs_n_i,
    input  wire logic           sclk_i,
    input  wire logic           sdio_i,
    output logic                sdio_o,
    output logic                sdio_oe_o,
    output logic                readback_output_pin_o,
    output logic                readback_output_pin_oe_o,
    // Power and alignment controls
    output scp_pkg::power_s     pwr_o,
    output logic                align_o
);

    scp_pkg::state_s   s_ff;
    scp_pkg::state_s   nxt_s;
    logic [7:0]        buf_mem [0:scp_pkg::NUM_REGS-1];
    logic [7:0]        act_mem [0:scp_pkg::NUM_REGS-1];
    logic              rise;
    logic              lsb;
    logic              sdo_act;
    logic              soft_rst;
    logic              dist_pd;
    logic              pop;
    logic              push_rdy;
    scp_pkg::wr_entry_s head;
    logic [15:0]       sh_n;
    logic [7:0]        byte_in;
    logic [9:0]        a_step;
    logic [9:0]        rd_addr;
    logic [7:0]        rd_byte;
    logic [11:0]       lv_mode;

    // Default value of each register
    function automatic logic [7:0] dflt(input int idx);
        return (idx == 0) ? scp_pkg::PORT_CFG_RST : scp_pkg::OTHER_RST;
    endfunction : dflt

    // Live port configuration and power bits
    assign lsb      = act_mem[scp_pkg::ADDR_PORT_CFG][scp_pkg::BIT_LSB_FIRST];
    assign sdo_act  = act_mem[scp_pkg::ADDR_PORT_CFG][scp_pkg::BIT_SDO_ACT];
    assign soft_rst = act_mem[scp_pkg::ADDR_PORT_CFG][scp_pkg::BIT_SRST_LO]
                    & act_mem[scp_pkg::ADDR_PORT_CFG][scp_pkg::BIT_SRST_HI];
    assign dist_pd  = act_mem[scp_pkg::ADDR_DIST_CTRL][scp_pkg::BIT_DIST_PD];

    // Serial clock edge and incoming bit, either order
    assign rise    = sclk_i & ~s_ff.sclk_q & ~cs_n_i;
    assign sh_n    = lsb ? {sdio_i, s_ff.sh[15:1]} : {s_ff.sh[14:0], sdio_i};
    assign byte_in = lsb ? sh_n[15:8] : sh_n[7:0];

    // Next address: down with wrap to last when MSB first, up when LSB first
    assign a_step = lsb ? 10'(s_ff.addr + 10'h001) :
                    (s_ff.addr == 10'h000) ? scp_pkg::ADDR_LAST :
                    10'(s_ff.addr - 10'h001);

    // Readback source: buffer or active copy
    assign rd_addr = (s_ff.st == scp_pkg::ST_INSTR) ? sh_n[9:0] : a_step;
    assign rd_byte = (rd_addr > scp_pkg::ADDR_LAST) ? 8'h00 :
                     act_mem[scp_pkg::ADDR_READ_SEL][scp_pkg::BIT_READ_ACT] ?
                     act_mem[rd_addr] : buf_mem[rd_addr];

    // Write buffer drain side stalls for the cycle after an update
    assign head     = s_ff.fifo[0];
    assign pop      = (s_ff.fcnt != 2'h0) & ~s_ff.upd;
    assign push_rdy = (s_ff.fcnt != 2'h2);

    // Per-output LVPECL mode, sleep forces safe-off unless total off chosen
    for (genvar g = 0; g < scp_pkg::NUM_LVPECL; g++) begin : g_lv
        logic [1:0] fld;
        assign fld = act_mem[scp_pkg::ADDR_LVPECL0 + g][1:0];
        assign lv_mode[2*g +: 2] = (fld == scp_pkg::PECL_TOTAL) ? scp_pkg::PECL_TOTAL :
                                   ~sleep_pin_n_i ? scp_pkg::PECL_SAFE : fld;
    end

    // Next state
    always_comb begin
        logic [1:0]                cnt;
        scp_pkg::wr_entry_s [1:0]  f;
        logic                      push;
        logic                      last;
        logic [7:0]                o;
        cnt   = s_ff.fcnt;
        f     = s_ff.fifo;
        push  = 1'b0;
        last  = 1'b0;
        o     = 8'h00;
        nxt_s = s_ff;
        nxt_s.sclk_q = sclk_i;
        nxt_s.hold   = soft_rst;
        nxt_s.align  = s_ff.hold & ~soft_rst;
        nxt_s.upd    = pop & (head.addr == scp_pkg::ADDR_UPDATE)
                     & head.data[scp_pkg::BIT_UPDATE] & ~soft_rst;
        if (cs_n_i) begin
            if (s_ff.bit_cnt != 3'h0 || s_ff.st == scp_pkg::ST_DONE) begin
                nxt_s.st      = scp_pkg::ST_INSTR;
                nxt_s.ib      = 1'b0;
                nxt_s.bit_cnt = 3'h0;
            end
        end else if (rise) begin
            nxt_s.sh      = sh_n;
            nxt_s.bit_cnt = 3'(s_ff.bit_cnt + 3'h1);
            if (s_ff.bit_cnt == 3'h7) begin
                case (s_ff.st)
                    scp_pkg::ST_INSTR: begin
                        if (!s_ff.ib) begin
                            nxt_s.ib = 1'b1;
                        end else begin
                            nxt_s.ib     = 1'b0;
                            nxt_s.rd     = sh_n[15];
                            nxt_s.left   = sh_n[14:13];
                            nxt_s.stream = (sh_n[14:13] == scp_pkg::LEN_STREAM);
                            nxt_s.addr   = sh_n[9:0];
                            nxt_s.st     = scp_pkg::ST_DATA;
                            nxt_s.out_sh = rd_byte;
                            nxt_s.dout   = lsb ? rd_byte[0] : rd_byte[7];
                        end
                    end
                    scp_pkg::ST_DATA: begin
                        last = s_ff.stream ? (s_ff.addr == scp_pkg::ADDR_LAST) :
                                             (s_ff.left == 2'h0);
                        nxt_s.left = 2'(s_ff.left - 2'h1);
                        nxt_s.addr = a_step;
                        push       = ~s_ff.rd;
                        if (last) begin
                            nxt_s.st = scp_pkg::ST_DONE;
                        end else begin
                            nxt_s.out_sh = rd_byte;
                            nxt_s.dout   = lsb ? rd_byte[0] : rd_byte[7];
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (s_ff.st == scp_pkg::ST_DATA && s_ff.rd) begin
                o            = lsb ? {1'b0, s_ff.out_sh[7:1]} : {s_ff.out_sh[6:0], 1'b0};
                nxt_s.out_sh = o;
                nxt_s.dout   = lsb ? o[0] : o[7];
            end
        end
        // Two-entry write buffer
        if (pop) begin
            f[0] = f[1];
            cnt  = 2'(cnt - 2'h1);
        end
        if (push && push_rdy) begin
            f[cnt[0]] = '{addr: s_ff.addr, data: byte_in};
            cnt       = 2'(cnt + 2'h1);
        end
        nxt_s.fifo = f;
        nxt_s.fcnt = cnt;
        // PLL power state
        if (soft_rst) begin
            nxt_s.pll_pd    = 1'b0;
            nxt_s.sync_pend = 1'b0;
        end else if (s_ff.upd) begin
            case (act_mem[scp_pkg::ADDR_PLL_MODE][1:0])
                scp_pkg::PLL_ASYNC_PD: begin
                    nxt_s.pll_pd    = 1'b1;
                    nxt_s.sync_pend = 1'b0;
                end
                scp_pkg::PLL_SYNC_PD: begin
                    nxt_s.sync_pend = 1'b1;
                end
                default: begin
                    nxt_s.pll_pd    = 1'b0;
                    nxt_s.sync_pend = 1'b0;
                end
            endcase
        end else if (s_ff.sync_pend && cp_event_i) begin
            nxt_s.pll_pd    = 1'b1;
            nxt_s.sync_pend = 1'b0;
        end
        // Power outputs
        nxt_s.pwr.pll_off     = ~sleep_pin_n_i | s_ff.pll_pd;
        nxt_s.pwr.core_off    = ~sleep_pin_n_i | dist_pd;
        nxt_s.pwr.dist_off    = dist_pd;
        nxt_s.pwr.lvpecl_mode = lv_mode;
    end

    // State register, reset pin loads STATE_RST
    always_ff @(posedge clk_i) begin
        if (srst_i || !chip_reset_n_i) begin
            s_ff <= scp_pkg::STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Buffer and active registers
    always_ff @(posedge clk_i) begin
        if (srst_i || !chip_reset_n_i) begin
            for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
                buf_mem[i] <= dflt(i);
                act_mem[i] <= dflt(i);
            end
        end else if (soft_rst) begin
            for (int i = 1; i < scp_pkg::NUM_REGS; i++) begin
                buf_mem[i] <= dflt(i);
                act_mem[i] <= dflt(i);
            end
            if (pop && head.addr == scp_pkg::ADDR_PORT_CFG) begin
                buf_mem[0] <= head.data;
                act_mem[0] <= head.data;
            end
        end else if (pop && head.addr <= scp_pkg::ADDR_LAST) begin
            if (head.addr == scp_pkg::ADDR_UPDATE && head.data[scp_pkg::BIT_UPDATE]) begin
                for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
                    act_mem[i] <= buf_mem[i];
                end
            end
            if (head.addr == scp_pkg::ADDR_PORT_CFG) begin
                act_mem[0] <= head.data;
                buf_mem[0] <= head.data;
            end else if (head.addr == scp_pkg::ADDR_UPDATE) begin
                buf_mem[head.addr] <= head.data & 8'hFE; // Update bit self-clears
            end else begin
                buf_mem[head.addr] <= head.data;
            end
        end
    end

    // Pin drivers: data from flops, enables follow select and direction
    assign sdio_o                   = s_ff.dout;
    assign readback_output_pin_o    = s_ff.dout;
    assign sdio_oe_o                = ~cs_n_i & s_ff.rd & (s_ff.st == scp_pkg::ST_DATA)
                                    & ~sdo_act;
    assign readback_output_pin_oe_o = ~cs_n_i & s_ff.rd & (s_ff.st == scp_pkg::ST_DATA)
                                    & sdo_act;
    assign pwr_o                    = s_ff.pwr;
    assign align_o                  = s_ff.align;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !chip_reset_n_i);

    property p_float_cs;
        cs_n_i |-> !sdio_oe_o && !readback_output_pin_oe_o;
    endproperty
    a_float_cs: assert property (p_float_cs) else $error("data pin driven with select high");

    property p_mid_byte;
        cs_n_i && s_ff.bit_cnt != 3'h0 |=> s_ff.st == scp_pkg::ST_INSTR && s_ff.bit_cnt == 3'h0;
    endproperty
    a_mid_byte: assert property (p_mid_byte) else $error("partial byte not dropped");

    property p_sleep_off;
        !sleep_pin_n_i [*2] |-> pwr_o.pll_off && pwr_o.core_off
                               && pwr_o.lvpecl_mode[1:0] != scp_pkg::PECL_ON;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep did not power down");

    property p_async_pd;
        s_ff.upd && !soft_rst && act_mem[scp_pkg::ADDR_PLL_MODE][1:0] == scp_pkg::PLL_ASYNC_PD
            |=> s_ff.pll_pd ##1 pwr_o.pll_off;
    endproperty
    a_async_pd: assert property (p_async_pd) else $error("async PLL power-down late");

    property p_sync_wait;
        s_ff.upd && !soft_rst && !s_ff.pll_pd
            && act_mem[scp_pkg::ADDR_PLL_MODE][1:0] == scp_pkg::PLL_SYNC_PD
            ##1 !cp_event_i |=> !s_ff.pll_pd;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("sync PLL power-down early");

    property p_soft_now;
        pop && head.addr == scp_pkg::ADDR_PORT_CFG && head.data[scp_pkg::BIT_SRST_LO]
            && head.data[scp_pkg::BIT_SRST_HI] |=> soft_rst ##1 !s_ff.pll_pd;
    endproperty
    a_soft_now: assert property (p_soft_now) else $error("soft reset not immediate");

    property p_update_copy;
        pop && !soft_rst && head.addr == scp_pkg::ADDR_UPDATE && head.data[scp_pkg::BIT_UPDATE]
            |=> act_mem[scp_pkg::ADDR_DIST_CTRL] == $past(buf_mem[scp_pkg::ADDR_DIST_CTRL]);
    endproperty
    a_update_copy: assert property (p_update_copy) else $error("update did not copy");

    property p_align_soft;
        $fell(soft_rst) |-> ##1 align_o ##1 !align_o;
    endproperty
    a_align_soft: assert property (p_align_soft) else $error("no alignment pulse");

    property p_sdo_mode;
        readback_output_pin_oe_o |-> sdo_act && !sdio_oe_o && s_ff.rd;
    endproperty
    a_sdo_mode: assert property (p_sdo_mode) else $error("wrong readback pin");

    property p_lsb_step;
        rise && lsb && s_ff.st == scp_pkg::ST_DATA && s_ff.bit_cnt == 3'h7
            |=> s_ff.addr == 10'($past(s_ff.addr) + 10'h001);
    endproperty
    a_lsb_step: assert property (p_lsb_step) else $error("address did not step up");

    property p_pecl_total;
        act_mem[scp_pkg::ADDR_LVPECL0][1:0] == scp_pkg::PECL_TOTAL
            |=> pwr_o.lvpecl_mode[1:0] == scp_pkg::PECL_TOTAL;
    endproperty
    a_pecl_total: assert property (p_pecl_total) else $error("total off not kept");

    c_write: cover property (pop && head.addr != scp_pkg::ADDR_UPDATE);
    c_read:  cover property (sdio_oe_o ##1 s_ff.st == scp_pkg::ST_DONE);
    c_stall: cover property (cs_n_i && s_ff.st == scp_pkg::ST_DATA && s_ff.bit_cnt == 3'h0);
    c_upd:   cover property (s_ff.upd);
    c_sleep: cover property (!sleep_pin_n_i ##1 sdio_oe_o);

endmodule : serial_config_port

// ==== spi_host_model.sv ====
// Host serial master model that drives the configuration port pins
`timescale 1ns/100ps
module spi_host_model (
    // Clock
    input  wire logic        clk_i,
    // Port pins
    output logic             cs_n_o,
    output logic             sclk_o,
    output logic             line_o,
    input  wire logic        dev_d_i,
    input  wire logic        dev_oe_i,
    input  wire logic        rb_i,
    input  wire logic        rb_oe_i,
    // Bits seen at each falling serial edge
    output logic [31:0]      cap_o
);
    logic host_d;
    logic host_oe;
    logic last_ff;

    // Shared line; with nobody driving it toggles so stale data never reads back
    assign line_o = dev_oe_i ? dev_d_i : (host_oe ? host_d : ~last_ff);

    // Last line level
    always_ff @(posedge clk_i) begin
        last_ff <= line_o;
    end

    // Idle pins: select high, serial clock low between frames
    initial begin
        cs_n_o  = 1'b1;
        sclk_o  = 1'b0;
        host_d  = 1'b0;
        host_oe = 1'b0;
        cap_o   = '0;
    end

    // Select edge, then a settling gap
    task automatic sel(input logic v);
        @(posedge clk_i);
        cs_n_o  <= v;
        host_oe <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : sel

    // Shift n bits out, sample readback at each falling edge
    task automatic shift(input int n, input logic [31:0] d, input logic drv);
        for (int i = n - 1; i >= 0; i--) begin
            host_oe <= drv;
            host_d  <= d[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            cap_o  <= {cap_o[30:0], rb_oe_i ? rb_i : line_o};
        end
        repeat (2) @(posedge clk_i);
    endtask : shift
endmodule : spi_host_model

// ==== testbench.sv ====
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
module testbench;
    logic            clk_i;
    logic            srst_i;
    logic            rst_n;
    logic            sleep_n;
    logic            cp_ev;
    wire logic            cs_n;
    wire logic            sclk;
    wire logic            line;
    wire logic            sd_o;
    wire logic            sd_oe;
    wire logic            rb;
    wire logic            rb_oe;
    wire logic [31:0]     cap;
    wire scp_pkg::power_s pwr;
    wire logic            align;
    int              fail_count = 0;
    int              compares = 0;
    int              aligns = 0;
    int              oe_cnt = 0;
    int              a0;
    int              o0;
    logic [7:0]      v;
    logic [1:0]      pm [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
    logic            pe [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

    serial_config_port DUT (
        .clk_i                    (clk_i),
        .srst_i                   (srst_i),
        .chip_reset_n_i           (rst_n),
        .sleep_pin_n_i            (sleep_n),
        .cp_event_i               (cp_ev),
        .cs_n_i                   (cs_n),
        .sclk_i                   (sclk),
        .sdio_i                   (line),
        .sdio_o                   (sd_o),
        .sdio_oe_o                (sd_oe),
        .readback_output_pin_o    (rb),
        .readback_output_pin_oe_o (rb_oe),
        .pwr_o                    (pwr),
        .align_o                  (align)
    );

    spi_host_model u_host (
        .clk_i    (clk_i),
        .cs_n_o   (cs_n),
        .sclk_o   (sclk),
        .line_o   (line),
        .dev_d_i  (sd_o),
        .dev_oe_i (sd_oe),
        .rb_i     (rb),
        .rb_oe_i  (rb_oe),
        .cap_o    (cap)
    );

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Count alignment pulses and cycles with the shared pin driven
    always_ff @(posedge clk_i) begin
        if (align === 1'b1) aligns <= aligns + 1;
        if (sd_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] ins(input logic r, input logic [1:0] len,
                                        input logic [9:0] a);
        return {16'h0000, r, len, 3'b000, a};
    endfunction : ins

    // Bit order reversal for least-significant-first frames
    function automatic logic [15:0] rev(input logic [15:0] x);
        logic [15:0] y;
        for (int i = 0; i < 16; i++) begin
            y[i] = x[15 - i];
        end
        return y;
    endfunction : rev

    // Write 1..3 bytes (stream sends 3), first byte at the start address
    task automatic wr(input logic [9:0] a, input logic [1:0] len, input logic [23:0] d);
        int nb;
        nb = (len == scp_pkg::LEN_STREAM) ? 3 : int'(len) + 1;
        u_host.sel(1'b0);
        u_host.shift(16, ins(1'b0, len, a), 1'b1);
        u_host.shift(8 * nb, {8'h00, d}, 1'b1);
        u_host.sel(1'b1);
    endtask : wr

    // Single-byte read, host releases the line for the data phase
    task automatic rd(input logic [9:0] a, output logic [7:0] r);
        u_host.sel(1'b0);
        u_host.shift(16, ins(1'b1, 2'h0, a), 1'b1);
        u_host.shift(8, 32'h0000_0000, 1'b0);
        r = cap[8:1];
        u_host.sel(1'b1);
    endtask : rd

    task automatic upd;
        wr(scp_pkg::ADDR_UPDATE, 2'h0, 24'h00_0001);
        repeat (10) @(posedge clk_i);
    endtask : upd

    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        $display("MISMATCH %0t timeout", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        srst_i  = 1'b1;
        rst_n   = 1'b1;
        sleep_n = 1'b1;
        cp_ev   = 1'b0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(16'(aligns), 16'h0001, "power-up align");
        chk({1'b0, pwr}, 16'h0000, "power-up state");
        chk({14'h0000, sd_oe, rb_oe}, 16'h0000, "pins float");
        rd(scp_pkg::ADDR_PORT_CFG, v);
        chk({8'h00, v}, 16'h0018, "port config default");
        chk(16'(oe_cnt > 0), 16'h0001, "shared pin used");
        wr(scp_pkg::ADDR_DIST_CTRL, 2'h0, 24'h00_0002);
        rd(scp_pkg::ADDR_DIST_CTRL, v);
        chk({8'h00, v}, 16'h0002, "buffered byte");
        chk({1'b0, pwr}, 16'h0000, "not active before update");
        wr(10'h0F2, 2'h2, 24'h02_0300);
        u_host.sel(1'b0);
        u_host.shift(16, ins(1'b0, 2'h0, 10'h0F5), 1'b1);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        u_host.shift(8, 32'h0000_0003, 1'b1);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        u_host.shift(20, 32'({16'(ins(1'b0, 2'h0, 10'h0F4)), 4'hF}), 1'b1);
        u_host.sel(1'b1);
        rd(10'h0F4, v);
        chk({8'h00, v}, 16'h0000, "partial byte dropped");
        upd();
        chk({1'b0, pwr}, {4'h3, 12'hC2C}, "dist down, modes");
        a0 = aligns;
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({1'b0, pwr}, {4'h7, 12'hEAE}, "sleep state");
        rd(10'h0F1, v);
        chk({8'h00, v}, 16'h0003, "port live in sleep");
        wr(scp_pkg::ADDR_DIST_CTRL, 2'h0, 24'h00_0000);
        wr(10'h0F0, 2'h0, 24'h00_0003);
        wr(10'h001, scp_pkg::LEN_STREAM, 24'h00_1801);
        repeat (10) @(posedge clk_i);
        sleep_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({1'b0, pwr}, {4'h0, 12'hC2F}, "wake with new settings");
        chk(16'(aligns - a0), 16'h0000, "no align on wake");
        for (int i = 0; i < 4; i++) begin
            wr(scp_pkg::ADDR_PLL_MODE, 2'h0, {22'h00_0000, pm[i]});
            upd();
            chk(16'(pwr.pll_off), 16'(pe[i]), "pll mode");
        end
        @(posedge clk_i);
        cp_ev <= 1'b1;
        @(posedge clk_i);
        cp_ev <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(16'(pwr.pll_off), 16'h0001, "pll off at pump event");
        wr(scp_pkg::ADDR_PORT_CFG, 2'h0, 24'h00_0099);
        o0 = oe_cnt;
        rd(10'h0F1, v);
        chk({8'h00, v}, 16'h0003, "readback pin data");
        chk(16'(oe_cnt - o0), 16'h0000, "shared pin input only");
        wr(scp_pkg::ADDR_PORT_CFG, 2'h0, 24'h00_003C);
        repeat (4) @(posedge clk_i);
        chk({1'b0, pwr}, 16'h0000, "soft reset without update");
        a0 = aligns;
        wr(scp_pkg::ADDR_PORT_CFG, 2'h0, 24'h00_0018);
        repeat (4) @(posedge clk_i);
        chk(16'(aligns - a0), 16'h0001, "align after soft reset");
        rd(10'h0F1, v);
        chk({8'h00, v}, 16'h0000, "defaults after soft reset");
        // Stall after one byte, then abort with a three-bit select pulse
        u_host.sel(1'b0);
        u_host.shift(24, 32'({16'(ins(1'b0, 2'h2, 10'h0F5)), 8'h01}), 1'b1);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        u_host.shift(3, 32'h0000_0007, 1'b1);
        u_host.sel(1'b1);
        rd(10'h0F4, v);
        chk({8'h00, v}, 16'h0000, "abort drops rest");
        rd(10'h0F5, v);
        chk({8'h00, v}, 16'h0001, "byte before abort kept");
        // Least-significant-first two-byte write, then back to default order
        wr(scp_pkg::ADDR_PORT_CFG, 2'h0, 24'h00_0042);
        u_host.sel(1'b0);
        u_host.shift(32, {rev(16'(ins(1'b0, 2'h1, 10'h0F2))), rev(16'h0201)}, 1'b1);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        u_host.shift(24, {8'h00, rev(16'(ins(1'b0, 2'h0, scp_pkg::ADDR_PORT_CFG))), 8'h18}, 1'b1);
        u_host.sel(1'b1);
        rd(10'h0F3, v);
        chk({8'h00, v}, 16'h0002, "LSB first address steps up");
        rd(10'h0F2, v);
        chk({8'h00, v}, 16'h0001, "LSB first byte order");
        wr(scp_pkg::ADDR_DIST_CTRL, 2'h0, 24'h00_0002);
        upd();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({1'b0, pwr}, 16'h0000, "reset pin clears");
        rd(scp_pkg::ADDR_DIST_CTRL, v);
        chk({8'h00, v}, 16'h0000, "register default after pin");
        tally_and_finish();
    end
endmodule : testbench
